//--- bcps_pkg.sv
/*
 * Constants and types shared by the start-up configuration loader and its ROM page table.
 * Assumes three-level strap pins arrive already resolved into a two-bit level code.
 */
package bcps_pkg;

    // =========================================================================
    // Strap level codes
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_MID  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // =========================================================================
    // Stored EEPROM byte layout
    localparam int EE_OVERLAY_BIT = 7;
    localparam int EE_OFFSET_MSB  = 6;
    localparam int EE_OFFSET_LSB  = 3;
    localparam logic [3:0] EE_OFFSET_DEFAULT = 4'h0;

    // =========================================================================
    // Page numbering
    localparam logic [4:0] PAGE_LAST      = 5'h08;
    localparam logic [4:0] PAGE_LOW_POWER = 5'h03;
    localparam int OUT_COUNT = 16;
    localparam int FREQ_W    = 4;

    // =========================================================================
    // Output frequency codes
    localparam logic [3:0] FQ_NONE  = 4'h0;
    localparam logic [3:0] FQ_1PPS  = 4'h1;
    localparam logic [3:0] FQ_1_92  = 4'h2;
    localparam logic [3:0] FQ_7_68  = 4'h3;
    localparam logic [3:0] FQ_20_48 = 4'h4;

    // =========================================================================
    // Reference oscillator codes
    localparam logic [3:0] OSC_NONE  = 4'h0;
    localparam logic [3:0] OSC_20    = 4'h1;
    localparam logic [3:0] OSC_38_88 = 4'h2;
    localparam logic [3:0] OSC_48    = 4'h3;
    localparam logic [3:0] OSC_54    = 4'h4;

    // =========================================================================
    // Loader states
    typedef enum logic [1:0] {
        ST_STRAP   = 2'h0,
        ST_ROM     = 2'h1,
        ST_OVERLAY = 2'h3,
        ST_DONE    = 2'h2
    } bcps_state_t;

endpackage

//--- bcps_rom_if.sv
/*
 * Carrier between the loader and its ROM page table.
 * Assumes both ends run on the same clock; the lookup is purely combinational.
 */
`timescale 1ns/1ns

interface bcps_rom_if;
    logic [4:0]  page;
    logic        page_valid;
    logic [3:0]  osc;
    logic [63:0] freq;
    logic [15:0] dis;

    modport rom (
        input  page,
        output page_valid,
        output osc,
        output freq,
        output dis
    );

    modport user (
        output page,
        input  page_valid,
        input  osc,
        input  freq,
        input  dis
    );
endinterface

//--- bcps_rom.sv
/*
 * Fixed ROM page table: oscillator, output frequency codes and parked-output mask per page.
 * Assumes the caller presents a page number; pages past the last read as unconfigured.
 */
`timescale 1ns/1ns

module bcps_rom
    import bcps_pkg::*;
(
    // Page lookup
    bcps_rom_if.rom rom_bus
);

    // =========================================================================
    // Constant contents, output 15 in the top nibble. No write path exists.
    always_comb begin // [RULE10]
        rom_bus.page_valid = 1'b1;
        rom_bus.osc        = OSC_48;
        rom_bus.freq       = 64'h0;
        rom_bus.dis        = 16'h0;
        case (rom_bus.page)
            5'h00: rom_bus.freq = 64'hEE2E2E2EDDDDC877;
            5'h01: begin
                rom_bus.freq = 64'hDD2E2E882EEE77E2;
                rom_bus.dis  = 16'hBFB7;
            end
            5'h02: begin
                rom_bus.freq = 64'hD92E2E282EE277E2;
                rom_bus.dis  = 16'h0A91;
            end
            5'h03: begin
                rom_bus.osc  = OSC_38_88;
                rom_bus.freq = 64'hDA828282AAAA7752;
                rom_bus.dis  = 16'hFFFF;
            end
            5'h04: begin
                rom_bus.osc  = OSC_54;
                rom_bus.freq = 64'h00EECC88BBBB6699;
            end
            5'h05: begin
                rom_bus.osc  = OSC_20;
                rom_bus.freq = 64'hEE3E3E3E3CECAA97;
                rom_bus.dis  = 16'hC000;
            end
            5'h06: begin
                rom_bus.freq = 64'hDA483E3CAA957791;
                rom_bus.dis  = 16'hDFA1;
            end
            5'h07: begin
                rom_bus.freq = 64'hCC483E3CAA957791;
                rom_bus.dis  = 16'hD000;
            end
            5'h08: rom_bus.freq = 64'h000000008E3EAD59;
            default: begin
                rom_bus.page_valid = 1'b0;
                rom_bus.osc        = OSC_NONE;
            end
        endcase
    end

endmodule

//--- bcps_boot_config_page_select.sv
/*
 * Power-on configuration loader: strap capture, host interface choice, ROM page load
 * and optional EEPROM overlay of oscillator, analog PLL and output driver settings.
 * Assumes stored EEPROM values are stable at its inputs from reset release until boot_done rises.
 */
`timescale 1ns/1ns

// Summary of operation
// [RULE1] Overlay off: ROM page only, no overlay
// [RULE2] Overlay on: ROM, then oscillator/PLL/outputs overwritten
// [RULE3] Host later writes DPLL, frame-reference, GPIO
// [RULE4] Host may later overwrite any ROM setting
// [RULE5] Interface strap low gives I2C, high SPI
// [RULE6] I2C: shared pin selects address level
// [RULE7] SPI: shared pin acts as chip select
// [RULE8] Page from both page pins plus offset
// [RULE9] Stored offset defaults to zero
// [RULE10] ROM pages are fixed, never writable
// [RULE11] Two-level pin pairs give pages 0-3
// [RULE12] Page 3 turns all PLLs, outputs off
// [RULE13] Mid-level combinations give pages 4-8
// [RULE14] Unconfigured channels stay disabled
// [RULE15] Parked outputs keep divider, stay disabled
// [RULE16] Low-rate marked outputs use frame-reference divider
// [RULE17] Stored overlay bit chooses overlay or not
// [RULE18] Overlay never touches DPLL, frame-reference, GPIO
// [RULE19] Straps latched once at reset release
module bcps_boot_config_page_select
    import bcps_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Strap pins
    input  wire logic        interface_select_pin,
    input  wire logic [1:0]  page_select_pin_a,
    input  wire logic [1:0]  page_select_pin_b,
    input  wire logic [1:0]  chip_select_or_address_pin,
    // Stored EEPROM contents
    input  wire logic [7:0]  ee_boot_byte,
    input  wire logic [3:0]  ee_osc_code,
    input  wire logic        ee_apll_en,
    input  wire logic [63:0] ee_out_freq,
    input  wire logic [15:0] ee_out_dis,
    // Host interface selection
    output logic             spi_mode,
    output logic [1:0]       i2c_addr_sel,
    output logic             spi_chip_select_active,
    // Loaded configuration
    output logic             boot_done,
    output logic [4:0]       page_index,
    output logic             page_valid,
    output logic [3:0]       osc_code,
    output logic             apll_en,
    output logic             dpll_en,
    output logic             frame_ref_en,
    output logic [1:0]       in_en,
    output logic [63:0]      out_freq,
    output logic [15:0]      out_en,
    output logic [15:0]      out_frame_ref
);

    // =========================================================================
    // Helpers
    function automatic logic [15:0] enable_mask(input logic [63:0] f, input logic [15:0] d);
        logic [15:0] m;
        m = 16'h0;
        for (int i = 0; i < OUT_COUNT; i++) begin
            m[i] = (f[i*FREQ_W +: FREQ_W] != FQ_NONE) && !d[i]; // [RULE14] [RULE15]
        end
        return m;
    endfunction

    function automatic logic [15:0] frame_mask(input logic [63:0] f);
        logic [15:0] m;
        logic [3:0]  c;
        m = 16'h0;
        c = 4'h0;
        for (int i = 0; i < OUT_COUNT; i++) begin
            c    = f[i*FREQ_W +: FREQ_W];
            m[i] = (c >= FQ_1PPS) && (c <= FQ_20_48); // [RULE16]
        end
        return m;
    endfunction

    function automatic logic [1:0] level(input logic [1:0] code);
        return (code == 2'h3) ? LVL_MID : code;
    endfunction

    function automatic logic [4:0] base_page(input logic [1:0] b, input logic [1:0] a);
        logic [4:0] p;
        p = 5'h00;
        case ({level(b), level(a)})
            {LVL_LOW,  LVL_LOW }: p = 5'h00; // [RULE11]
            {LVL_LOW,  LVL_HIGH}: p = 5'h01;
            {LVL_HIGH, LVL_LOW }: p = 5'h02;
            {LVL_HIGH, LVL_HIGH}: p = 5'h03;
            {LVL_LOW,  LVL_MID }: p = 5'h04; // [RULE13]
            {LVL_MID,  LVL_LOW }: p = 5'h05;
            {LVL_MID,  LVL_MID }: p = 5'h06;
            {LVL_MID,  LVL_HIGH}: p = 5'h07;
            {LVL_HIGH, LVL_MID }: p = 5'h08;
            default:              p = 5'h00;
        endcase
        return p;
    endfunction

    // =========================================================================
    // State
    bcps_state_t state_reg, state_next;
    logic        spi_reg, spi_next;
    logic [1:0]  addr_reg, addr_next;
    logic [4:0]  page_reg, page_next;
    logic        overlay_reg, overlay_next;
    logic        done_reg, done_next;
    logic        valid_reg, valid_next;
    logic [3:0]  osc_reg, osc_next;
    logic        apll_reg, apll_next;
    logic        dpll_reg, dpll_next;
    logic        fref_reg, fref_next;
    logic [1:0]  in_reg, in_next;
    logic [63:0] freq_reg, freq_next;
    logic [15:0] en_reg, en_next;
    logic [15:0] fmask_reg, fmask_next;
    logic        low_power;

    bcps_rom_if rom_bus ();

    bcps_rom u_rom (
        .rom_bus (rom_bus)
    );

    assign rom_bus.page = page_reg;
    assign low_power    = (page_reg == PAGE_LOW_POWER);

    // =========================================================================
    // Next-state logic
    always_comb begin
        state_next   = state_reg;
        spi_next     = spi_reg;
        addr_next    = addr_reg;
        page_next    = page_reg;
        overlay_next = overlay_reg;
        done_next    = done_reg;
        valid_next   = valid_reg;
        osc_next     = osc_reg;
        apll_next    = apll_reg;
        dpll_next    = dpll_reg;
        fref_next    = fref_reg;
        in_next      = in_reg;
        freq_next    = freq_reg;
        en_next      = en_reg;
        fmask_next   = fmask_reg;
        case (state_reg)
            ST_STRAP: begin
                spi_next     = interface_select_pin; // [RULE5] [RULE19]
                addr_next    = level(chip_select_or_address_pin);
                page_next    = base_page(page_select_pin_b, page_select_pin_a)
                             + {1'b0, ee_boot_byte[EE_OFFSET_MSB:EE_OFFSET_LSB]}; // [RULE8]
                overlay_next = ee_boot_byte[EE_OVERLAY_BIT]; // [RULE17]
                state_next   = ST_ROM;
            end
            ST_ROM: begin
                valid_next = rom_bus.page_valid;
                osc_next   = rom_bus.osc;
                apll_next  = rom_bus.page_valid && !low_power; // [RULE12]
                dpll_next  = rom_bus.page_valid && !low_power;
                fref_next  = rom_bus.page_valid && !low_power && (|frame_mask(rom_bus.freq));
                in_next    = {2{rom_bus.page_valid && !low_power}};
                freq_next  = rom_bus.freq;
                en_next    = enable_mask(rom_bus.freq, rom_bus.dis);
                fmask_next = frame_mask(rom_bus.freq);
                state_next = overlay_reg ? ST_OVERLAY : ST_DONE; // [RULE1] [RULE2]
            end
            ST_OVERLAY: begin
                osc_next   = ee_osc_code; // [RULE2]
                apll_next  = ee_apll_en;
                freq_next  = ee_out_freq;
                en_next    = enable_mask(ee_out_freq, ee_out_dis); // [RULE18]
                state_next = ST_DONE;
            end
            ST_DONE: begin
                done_next = 1'b1;
            end
            default: begin
                state_next = ST_STRAP;
            end
        endcase
    end

    // =========================================================================
    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg   <= ST_STRAP;
            spi_reg     <= 1'b0;
            addr_reg    <= LVL_LOW;
            page_reg    <= {1'b0, EE_OFFSET_DEFAULT}; // [RULE9]
            overlay_reg <= 1'b0;
            done_reg    <= 1'b0;
            valid_reg   <= 1'b0;
            osc_reg     <= OSC_NONE;
            apll_reg    <= 1'b0;
            dpll_reg    <= 1'b0;
            fref_reg    <= 1'b0;
            in_reg      <= 2'h0;
            freq_reg    <= 64'h0;
            en_reg      <= 16'h0;
            fmask_reg   <= 16'h0;
        end else begin
            state_reg   <= state_next;
            spi_reg     <= spi_next;
            addr_reg    <= addr_next;
            page_reg    <= page_next;
            overlay_reg <= overlay_next;
            done_reg    <= done_next;
            valid_reg   <= valid_next;
            osc_reg     <= osc_next;
            apll_reg    <= apll_next;
            dpll_reg    <= dpll_next;
            fref_reg    <= fref_next;
            in_reg      <= in_next;
            freq_reg    <= freq_next;
            en_reg      <= en_next;
            fmask_reg   <= fmask_next;
        end
    end

    // =========================================================================
    // Outputs
    assign spi_mode               = spi_reg;
    assign i2c_addr_sel           = spi_reg ? LVL_LOW : addr_reg; // [RULE6]
    assign spi_chip_select_active = spi_reg && (chip_select_or_address_pin == LVL_LOW); // [RULE7]
    assign boot_done              = done_reg;
    assign page_index             = page_reg;
    assign page_valid             = valid_reg;
    assign osc_code               = osc_reg;
    assign apll_en                = apll_reg;
    assign dpll_en                = dpll_reg;
    assign frame_ref_en           = fref_reg;
    assign in_en                  = in_reg;
    assign out_freq               = freq_reg;
    assign out_en                 = en_reg;
    assign out_frame_ref          = fmask_reg;

    // =========================================================================
    // Checks
    a_rom_only_skip: assert property (@(posedge clock) disable iff (rst) // [RULE1]
        (state_reg == ST_ROM) && !overlay_reg |=> (state_reg == ST_DONE) ##1 done_reg)
        else $error("ROM-only start did not finish directly");
    a_overlay_apply: assert property (@(posedge clock) disable iff (rst) // [RULE2]
        (state_reg == ST_OVERLAY) |=> (osc_code == $past(ee_osc_code))
            && (out_freq == $past(ee_out_freq)) && (apll_en == $past(ee_apll_en)))
        else $error("Overlay values not applied");
    a_iface_strap: assert property (@(posedge clock) disable iff (rst) // [RULE5]
        (state_reg == ST_STRAP) |=> (spi_mode == $past(interface_select_pin)))
        else $error("Interface strap not captured");
    a_chip_select: assert property (@(posedge clock) disable iff (rst) // [RULE7]
        !spi_mode |-> !spi_chip_select_active)
        else $error("Chip select active in I2C mode");
    a_strap_hold: assert property (@(posedge clock) disable iff (rst) // [RULE19]
        (state_reg != ST_STRAP) |=> $stable(spi_mode) && $stable(page_index)
            && $stable(i2c_addr_sel))
        else $error("Strap values changed after capture");
    a_low_power: assert property (@(posedge clock) disable iff (rst) // [RULE12]
        (state_reg == ST_ROM) && low_power |=> !apll_en && !dpll_en && (out_en == 16'h0)
            && (in_en == 2'h0))
        else $error("Low-power page left something running");
    a_unconf_off: assert property (@(posedge clock) disable iff (rst) // [RULE14]
        (out_en & ~enable_mask(out_freq, 16'h0)) == 16'h0)
        else $error("Unconfigured output enabled");
    a_rom_owned: assert property (@(posedge clock) disable iff (rst) // [RULE18]
        (state_reg == ST_OVERLAY) |=> $stable(dpll_en) && $stable(frame_ref_en)
            && $stable(out_frame_ref))
        else $error("Overlay touched ROM-owned settings");

endmodule

//--- bcps_host_model.sv
/*
 * Far-side model for the loader: drives the strap pins the board and host present.
 * Assumes the bench sets the wanted levels and the wander flag at the falling edge.
 */
`timescale 1ns/1ns

module bcps_host_model
    import bcps_pkg::*;
(
    // Clock and control
    input  wire logic        clock,
    input  wire logic        wander,
    // Wanted strap levels
    input  wire logic        ifsel_set,
    input  wire logic [1:0]  pa_set,
    input  wire logic [1:0]  pb_set,
    input  wire logic [1:0]  cs_set,
    // Pins to the device
    output logic             ifsel,
    output logic [1:0]       pa,
    output logic [1:0]       pb,
    output logic [1:0]       cs
);
    // =========================================================================
    // Pin driver
    initial begin
        ifsel = 1'b0;
        pa    = LVL_LOW;
        pb    = LVL_LOW;
        cs    = LVL_LOW;
    end

    // Straps follow the wanted levels while wander is low; while wander is high they change every cycle.
    always @(negedge clock) begin
        if (wander) begin
            ifsel <= ~ifsel;
            pa    <= (pa == LVL_HIGH) ? LVL_LOW : pa + 2'h1;
            pb    <= (pb == LVL_LOW) ? LVL_HIGH : pb - 2'h1;
            cs    <= (cs == LVL_LOW) ? LVL_HIGH : LVL_LOW;
        end else begin
            ifsel <= ifsel_set;
            pa    <= pa_set;
            pb    <= pb_set;
            cs    <= cs_set;
        end
    end
endmodule

//--- bcps_boot_config_page_select_tb.sv
/*
 * Self-checking bench for the start-up loader: strap capture, page choice, overlay.
 * Assumes the host model drives the straps and the bench supplies stored EEPROM values.
 */
`timescale 1ns/1ns

module bcps_boot_config_page_select_tb
    import bcps_pkg::*;
;
    typedef struct {
        logic [4:0]  page;
        logic        valid, spi, ov, re, apll;
        logic [1:0]  addr;
        logic [3:0]  osc;
        logic [63:0] fq;
        logic [15:0] dis;
    } bcps_note_t;

    // =========================================================================
    // Signals
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        wander = 1'b0;
    logic        recheck = 1'b0;
    logic        ifsel_set = 1'b0;
    logic [1:0]  pa_set = 2'h0, pb_set = 2'h0, cs_set = 2'h0;
    logic        ifsel;
    logic [1:0]  pa, pb, cs;
    logic [7:0]  ee_boot_byte = 8'h00;
    logic [3:0]  ee_osc_code = 4'h0;
    logic        ee_apll_en = 1'b0;
    logic [63:0] ee_out_freq = 64'h0;
    logic [15:0] ee_out_dis = 16'h0;
    logic        spi_mode, spi_cs_act, boot_done, page_valid, apll_en, dpll_en, frame_ref_en;
    logic [1:0]  i2c_addr_sel, in_en;
    logic [4:0]  page_index;
    logic [3:0]  osc_code;
    logic [63:0] out_freq;
    logic [15:0] out_en, out_frame_ref;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    logic        seen = 1'b0;
    logic        live = 1'b0;
    logic [15:0] lfsr = 16'h89D0;
    bcps_note_t  notes[$];
    bcps_note_t  cur;

    initial begin
        forever #5 clock = ~clock;
    end

    // =========================================================================
    // Device and far side
    bcps_host_model host_u (.clock(clock), .wander(wander), .ifsel_set(ifsel_set),
        .pa_set(pa_set), .pb_set(pb_set), .cs_set(cs_set), .ifsel(ifsel), .pa(pa),
        .pb(pb), .cs(cs));

    bcps_boot_config_page_select dut_u (.clock(clock), .rst(rst),
        .interface_select_pin(ifsel), .page_select_pin_a(pa), .page_select_pin_b(pb),
        .chip_select_or_address_pin(cs), .ee_boot_byte(ee_boot_byte),
        .ee_osc_code(ee_osc_code), .ee_apll_en(ee_apll_en), .ee_out_freq(ee_out_freq),
        .ee_out_dis(ee_out_dis), .spi_mode(spi_mode), .i2c_addr_sel(i2c_addr_sel),
        .spi_chip_select_active(spi_cs_act), .boot_done(boot_done),
        .page_index(page_index), .page_valid(page_valid), .osc_code(osc_code),
        .apll_en(apll_en), .dpll_en(dpll_en), .frame_ref_en(frame_ref_en), .in_en(in_en),
        .out_freq(out_freq), .out_en(out_en), .out_frame_ref(out_frame_ref));

    // =========================================================================
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [4:0] base_page(input logic [1:0] b, input logic [1:0] a);
        logic [1:0] lb, la;
        lb = (b == 2'h3) ? LVL_MID : b;
        la = (a == 2'h3) ? LVL_MID : a;
        case ({lb, la})
            4'h0: return 5'h00;
            4'h2: return 5'h01;
            4'h8: return 5'h02;
            4'hA: return 5'h03;
            4'h1: return 5'h04;
            4'h4: return 5'h05;
            4'h5: return 5'h06;
            4'h6: return 5'h07;
            default: return 5'h08;
        endcase
    endfunction

    function automatic logic [3:0] rom_osc(input logic [4:0] p);
        return (p == 5'h04) ? OSC_54 : (p == 5'h05) ? OSC_20 : OSC_48;
    endfunction

    function automatic logic [15:0] ov_en(input logic [63:0] fq, input logic [15:0] dis);
        logic [15:0] e;
        for (int i = 0; i < 16; i++) begin
            e[i] = (fq[4*i +: 4] != FQ_NONE) && !dis[i];
        end
        return e;
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] want);
        n_compared++;
        if (got !== want) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, got, want);
        end
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // =========================================================================
    // Result watcher
    always @(posedge clock) begin
        cyc <= rst ? 0 : cyc + 1;
    end

    always @(negedge clock) begin
        if (rst) begin
            seen = 1'b0;
        end else if ((boot_done === 1'b1 && !seen) || recheck === 1'b1) begin
            seen = 1'b1;
            if (notes.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                cur = notes.pop_front();
                live = cur.valid && (cur.page != PAGE_LOW_POWER);
                check(64'(page_index), 64'(cur.page));
                check(64'(page_valid), 64'(cur.valid));
                check(64'(spi_mode), 64'(cur.spi));
                check(64'(i2c_addr_sel), 64'(cur.addr));
                if (!cur.re) check(64'(cyc), 64'(cur.ov ? 4 : 3));
                check(64'(dpll_en), 64'(live));
                check(64'(frame_ref_en), 64'(live && (cur.page != 5'h04)));
                if (cur.ov) begin
                    check(64'(osc_code), 64'(cur.osc));
                    check(64'(apll_en), 64'(cur.apll));
                    check(out_freq, cur.fq);
                    check(64'(out_en), 64'(ov_en(cur.fq, cur.dis)));
                end else if (!cur.valid) begin
                    check(out_freq, 64'h0);
                    check(64'({out_en, in_en}), 64'h0);
                end else if (cur.page == PAGE_LOW_POWER) begin
                    check(64'({apll_en, in_en, out_en}), 64'h0);
                end else begin
                    check(64'({osc_code, apll_en}), 64'({rom_osc(cur.page), 1'b1}));
                    check(64'(in_en), 64'h3);
                end
                case (cur.page)
                    5'h00: check(64'({out_frame_ref[9], out_frame_ref[0]}), 64'h2);
                    5'h01: check(64'(out_frame_ref[0]), 64'h1);
                    5'h02: check(64'(out_frame_ref[0]), 64'h1);
                    default: ;
                endcase
                if (!cur.ov) begin
                    case (cur.page)
                        5'h00: check(64'({out_freq[39:36], out_en[9]}), 64'h5);
                        5'h01: check(64'({out_freq[3:0], out_en[0]}), 64'h4);
                        5'h04: check(64'({out_freq[63:56], out_en[15:14]}), 64'h0);
                        5'h08: check(64'({out_freq[63:32], out_en[15:8]}), 64'h0);
                        default: ;
                    endcase
                end
            end
        end
    end

    // =========================================================================
    // Driver
    task automatic run(input logic i, input logic [1:0] b, input logic [1:0] a,
                       input logic [1:0] c, input logic [3:0] off, input logic ov);
        bcps_note_t n;
        @(negedge clock);
        rst = 1'b1;
        wander <= 1'b0;
        ifsel_set <= i;
        pb_set <= b;
        pa_set <= a;
        cs_set <= c;
        for (int k = 0; k < 5; k++) begin
            lfsr = lfsr_next(lfsr);
            if (k < 4) ee_out_freq[16*k +: 16] = lfsr;
        end
        ee_out_dis = lfsr;
        lfsr = lfsr_next(lfsr);
        ee_osc_code = lfsr[3:0];
        ee_apll_en = lfsr[4];
        ee_boot_byte = {ov, off, 3'h5};
        repeat (2) @(negedge clock);
        n.page = base_page(b, a) + {1'b0, off};
        n.valid = n.page <= PAGE_LAST;
        n.spi = i;
        n.addr = i ? LVL_LOW : c;
        n.ov = ov;
        n.re = 1'b0;
        n.osc = ee_osc_code;
        n.apll = ee_apll_en;
        n.fq = ee_out_freq;
        n.dis = ee_out_dis;
        notes.push_back(n);
        rst = 1'b0;
        for (int k = 0; k < 20 && boot_done !== 1'b1; k++) @(negedge clock);
        if (boot_done !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: loader never finished", $time);
            close_out();
        end
        wander <= 1'b1;
        repeat (8) begin
            @(posedge clock);
            check(64'(spi_cs_act), 64'(i && (cs == LVL_LOW)));
        end
        @(negedge clock);
        wander <= 1'b0;
        n.re = 1'b1;
        notes.push_back(n);
        recheck <= 1'b1;
        @(negedge clock);
        recheck <= 1'b0;
    endtask

    initial begin
        repeat (7) @(negedge clock);
        run(1'b0, LVL_LOW, LVL_LOW, LVL_MID, 4'h0, 1'b0);
        run(1'b0, LVL_LOW, LVL_HIGH, LVL_HIGH, 4'h0, 1'b0);
        run(1'b1, LVL_HIGH, LVL_LOW, LVL_LOW, 4'h0, 1'b1);
        run(1'b1, LVL_HIGH, LVL_HIGH, LVL_LOW, 4'h0, 1'b0);
        run(1'b0, LVL_LOW, LVL_MID, LVL_LOW, 4'h0, 1'b0);
        run(1'b1, LVL_MID, LVL_LOW, LVL_MID, 4'h0, 1'b0);
        run(1'b0, 2'h3, LVL_MID, LVL_HIGH, 4'h0, 1'b0);
        run(1'b0, LVL_MID, LVL_HIGH, LVL_MID, 4'h0, 1'b1);
        run(1'b1, LVL_HIGH, LVL_MID, LVL_HIGH, 4'h0, 1'b0);
        run(1'b0, LVL_LOW, LVL_LOW, LVL_LOW, 4'h1, 1'b0);
        run(1'b0, LVL_LOW, LVL_HIGH, LVL_LOW, 4'h8, 1'b0);
        run(1'b1, LVL_HIGH, LVL_HIGH, LVL_LOW, 4'h0, 1'b1);
        repeat (2) @(negedge clock);
        close_out();
    end
endmodule
